// *** verilog/scpi_consts.vh ***
// Constants for the command parser error classifier.
// Included by every design file; definitions only.
`ifndef SCPI_CONSTS_VH
`define SCPI_CONSTS_VH

// Error magnitudes; the queue reports the negated value
`define E_CMD        8'h64
`define E_INV_CHAR   8'h65
`define E_SYNTAX     8'h66
`define E_SEP        8'h67
`define E_DTYPE      8'h68
`define E_GET        8'h69
`define E_PAR_EXTRA  8'h6C
`define E_PAR_MISS   8'h6D
`define E_HDR        8'h6E
`define E_HDR_SEP    8'h6F
`define E_MNEM_LONG  8'h70
`define E_HDR_UNDEF  8'h71
`define E_NUM        8'h78
`define E_NUM_CHAR   8'h79
`define E_EXP_BIG    8'h7B
`define E_DIGITS     8'h7C
`define E_NUM_NA     8'h80
`define E_SFX_INV    8'h83
`define E_SFX_LONG   8'h86
`define E_SFX_NA     8'h8A
`define E_CHR_INV    8'h8D
`define E_CHR_LONG   8'h90
`define E_CHR_NA     8'h94
`define E_STR_INV    8'h97
`define E_STR_NA     8'h9E
`define E_BLK        8'hA0
`define E_BLK_INV    8'hA1

// Length and range limits
`define MNEM_MAX     8'h0C
`define SFX_MAX      8'h0C
`define CHR_MAX      8'h0C
`define DIG_MAX      9'h0FF
`define EXP_MAX      16'h7D00

// Error queue geometry
`define Q_DEPTH      4'h8
`define Q_AW         3

// Characters
`define CH_LF        8'h0A
`define CH_DQ        8'h22
`define CH_HASH      8'h23
`define CH_SQ        8'h27
`define CH_LPAR      8'h28
`define CH_STAR      8'h2A
`define CH_PLUS      8'h2B
`define CH_COMMA     8'h2C
`define CH_MINUS     8'h2D
`define CH_DOT       8'h2E
`define CH_SLASH     8'h2F
`define CH_0         8'h30
`define CH_1         8'h31
`define CH_7         8'h37
`define CH_COLON     8'h3A
`define CH_SEMI      8'h3B
`define CH_QMARK     8'h3F
`define CH_A         8'h41
`define CH_B         8'h42
`define CH_E         8'h45
`define CH_F         8'h46
`define CH_H         8'h48
`define CH_Q         8'h51
`define CH_UNDER     8'h5F

`endif

// *** verilog/char_class.v ***
// Combinational classification of one received byte.
// Pure decode; the parser samples the results with the byte.
`timescale 1ns/1ps
`include "scpi_consts.vh"

module char_class (
	input  wire [7:0] ch,
	output wire       is_alpha,
	output wire       is_digit,
	output wire       is_ws
);

	wire [7:0] up;

	assign up       = ch & 8'hDF;
	assign is_alpha = (up >= `CH_A) && (up <= 8'h5A);
	assign is_digit = (ch >= `CH_0) && (ch <= 8'h39);
	// Line feed is excluded: it terminates a message
	assign is_ws    = (ch <= 8'h20) && (ch != `CH_LF);

endmodule

// *** verilog/error_queue.v ***
// First-in first-out error queue with a read port.
// Assumes at most one push and one read request per cycle.
`timescale 1ns/1ps
`include "scpi_consts.vh"

module error_queue (
	input  wire        clock,
	input  wire        reset,
	input  wire        clear,
	input  wire        push,
	input  wire [7:0]  push_code,
	input  wire        read,
	output reg  [15:0] err_code_r,
	output reg         err_ack_r
);

	reg [7:0]       mem_r [0:`Q_DEPTH-1];
	reg [`Q_AW-1:0] rd_ptr_r;
	reg [`Q_AW-1:0] wr_ptr_r;
	reg [3:0]       count_r;

	wire pop;
	wire room;

	assign pop  = read && !clear && (count_r != 4'h0);
	// A full queue keeps its oldest entries and drops the newcomer, unless a read pops an entry in the same cycle
	assign room = (count_r != `Q_DEPTH) || pop;

	always @(posedge clock) begin
		if (reset) begin
			rd_ptr_r   <= {`Q_AW{1'b0}};
			wr_ptr_r   <= {`Q_AW{1'b0}};
			count_r    <= 4'h0;
			err_code_r <= 16'h0000;
			err_ack_r  <= 1'b0;
		end else begin
			err_ack_r <= read;
			if (pop)
				err_code_r <= 16'h0000 - {8'h00, mem_r[rd_ptr_r]};
			else if (read)
				err_code_r <= 16'h0000;
			if (clear) begin
				// An entry pushed during the clear survives it
				rd_ptr_r <= {`Q_AW{1'b0}};
				wr_ptr_r <= push ? {{(`Q_AW-1){1'b0}}, 1'b1}
				                 : {`Q_AW{1'b0}};
				count_r  <= push ? 4'h1 : 4'h0;
				if (push)
					mem_r[0] <= push_code;
			end else begin
				if (pop)
					rd_ptr_r <= rd_ptr_r + {{(`Q_AW-1){1'b0}}, 1'b1};
				if (push && room) begin
					mem_r[wr_ptr_r] <= push_code;
					wr_ptr_r <= wr_ptr_r + {{(`Q_AW-1){1'b0}}, 1'b1};
				end
				count_r <= count_r + {3'h0, push && room}
				                   - {3'h0, pop};
			end
		end
	end

endmodule

// *** verilog/scpi_parser_error_classifier.v ***
// Program message parser that classifies command errors and queues them.
// Assumes a header table outside answers combinationally from hdr_key
// and holds its answer until the next header starts.
// Operation
// - Reading an empty queue returns code 0, no error.
// - Power-on reset and clear-status discard every queued entry.
// - Syntax faults report a code in -199..-100 and set ESR bit 5.
// - Command errors never also produce execution, device or query errors.
// - Group execute trigger inside a program message reports -105.
// - Well-formed but unimplemented header reports -113.
// - Header mnemonic over twelve characters reports -112.
// - Numeric exponent magnitude above 32000 reports -123.
// - Mantissa over 255 significant digits reports -124.
// - Units suffix over 12 characters reports -134.
// - Character data over twelve characters reports -144.
// - Too many parameters report -108, too few report -109.
// - Generic group codes only when nothing more specific applies.
// - Invalid character in element gives -101; unknown type gives -102.
// - Illegal character where a separator belongs gives -103.
// - Recognised element of a disallowed type gives -104.
// - Header followed by a quote, hash, comma or left parenthesis gives -111.
// - Bad numeric character gives -121; numeric not accepted gives -128.
// - Suffix where none allowed gives -138; bad suffix gives -131.
// - Character data where prohibited gives -148; invalid gives -141.
// - String cut by END gives -151; string not accepted gives -158.
// - Block cut by END gives -161; other block faults give -160.
`timescale 1ns/1ps
`include "scpi_consts.vh"

module scpi_parser_error_classifier (
	input  wire        clock,
	input  wire        reset,
	input  wire        rx_valid,
	input  wire [7:0]  rx_byte,
	input  wire        rx_end,
	input  wire        get_trig,
	input  wire        clear_status,
	input  wire        err_read,
	input  wire        hdr_known,
	input  wire [3:0]  param_min,
	input  wire [3:0]  param_max,
	input  wire        allow_num,
	input  wire        allow_chr,
	input  wire        allow_str,
	input  wire        allow_blk,
	input  wire        sfx_ok,
	output wire [15:0] err_code,
	output wire        err_ack,
	output wire        esr_cmd_err,
	output wire [15:0] hdr_key
);

	localparam [3:0] S_UNIT   = 4'h0;
	localparam [3:0] S_HDR    = 4'h1;
	localparam [3:0] S_HWS    = 4'h2;
	localparam [3:0] S_PSTART = 4'h3;
	localparam [3:0] S_NUM    = 4'h4;
	localparam [3:0] S_EXP    = 4'h5;
	localparam [3:0] S_SFX    = 4'h6;
	localparam [3:0] S_NBASE  = 4'h7;
	localparam [3:0] S_NDIG   = 4'h8;
	localparam [3:0] S_CHR    = 4'h9;
	localparam [3:0] S_STR    = 4'hA;
	localparam [3:0] S_STRQ   = 4'hB;
	localparam [3:0] S_BLKN   = 4'hC;
	localparam [3:0] S_BLKD   = 4'hD;
	localparam [3:0] S_AFTER  = 4'hE;
	localparam [3:0] S_SKIP   = 4'hF;

	function [7:0] upper;
		input [7:0] c;
		begin
			upper = ((c >= 8'h61) && (c <= 8'h7A)) ? (c & 8'hDF) : c;
		end
	endfunction

	function [15:0] key_step;
		input [15:0] key;
		input [7:0]  c;
		begin
			key_step = {key[14:0], 1'b0} ^ {8'h00, upper(c)};
		end
	endfunction

	// Radix 0 hex, 1 octal, 2 binary
	function radix_ok;
		input [1:0] radix;
		input [7:0] c;
		reg   [7:0] u;
		begin
			u = upper(c);
			case (radix)
			2'h0: radix_ok = ((c >= `CH_0) && (c <= 8'h39)) ||
			                 ((u >= `CH_A) && (u <= `CH_F));
			2'h1: radix_ok = (c >= `CH_0) && (c <= `CH_7);
			2'h2: radix_ok = (c == `CH_0) || (c == `CH_1);
			default: radix_ok = 1'b0;
			endcase
		end
	endfunction

	reg [3:0]  state_r, state_nxt;
	reg [7:0]  len_r, len_nxt;
	reg [8:0]  dig_r, dig_nxt;
	reg        nz_r, nz_nxt;
	reg        ndig_r, ndig_nxt;
	reg        dot_r, dot_nxt;
	reg        expd_r, expd_nxt;
	reg        esgn_r, esgn_nxt;
	reg [15:0] exp_r, exp_nxt;
	reg [3:0]  cnt_r, cnt_nxt;
	reg [1:0]  radix_r, radix_nxt;
	reg [3:0]  bn_r, bn_nxt;
	reg [31:0] blen_r, blen_nxt;
	reg [7:0]  quote_r, quote_nxt;
	reg        colon_r, colon_nxt;
	reg        qmark_r, qmark_nxt;
	reg        lastnum_r, lastnum_nxt;
	reg [15:0] key_r, key_nxt;
	reg        in_msg_r, in_msg_nxt;
	reg        get_pend_r;
	reg        cmd_err_r;
	reg [7:0]  code;
	reg        sep;
	reg        estart;
	reg        endu;

	wire        is_alpha;
	wire        is_digit;
	wire        is_ws;
	wire [7:0]  c;
	wire [7:0]  uc;
	wire [3:0]  dv;
	wire        msg_end;
	wire        is_sep;
	wire [19:0] exp_calc;
	wire [35:0] blen_calc;
	wire [7:0]  num_err;
	wire        push;
	wire [7:0]  push_code;

	char_class u_class (
		.ch       (rx_byte),
		.is_alpha (is_alpha),
		.is_digit (is_digit),
		.is_ws    (is_ws)
	);

	assign c  = rx_byte;
	assign uc = upper(rx_byte);
	assign dv = rx_byte[3:0];
	// Line feed is data inside strings and blocks; only END ends those
	assign msg_end = rx_valid && (rx_end || ((c == `CH_LF) &&
	                 (state_r != S_STR) && (state_r != S_BLKD)));
	assign is_sep = is_ws || (c == `CH_COMMA) || (c == `CH_SEMI) || msg_end;
	assign exp_calc  = {4'h0, exp_r} * 20'h0000A + {16'h0000, dv};
	assign blen_calc = {4'h0, blen_r} * 36'h00000000A + {32'h0, dv};

	// Generic -120 only when no digit at all was seen
	assign num_err = !ndig_r ? `E_NUM :
	                 ((state_r == S_EXP) && !expd_r) ? `E_NUM_CHAR :
	                 (dig_r > `DIG_MAX) ? `E_DIGITS :
	                 (exp_r > `EXP_MAX) ? `E_EXP_BIG : 8'h00;

	always @* begin
		state_nxt   = state_r;
		len_nxt     = len_r;
		dig_nxt     = dig_r;
		nz_nxt      = nz_r;
		ndig_nxt    = ndig_r;
		dot_nxt     = dot_r;
		expd_nxt    = expd_r;
		esgn_nxt    = esgn_r;
		exp_nxt     = exp_r;
		cnt_nxt     = cnt_r;
		radix_nxt   = radix_r;
		bn_nxt      = bn_r;
		blen_nxt    = blen_r;
		quote_nxt   = quote_r;
		colon_nxt   = colon_r;
		qmark_nxt   = qmark_r;
		lastnum_nxt = lastnum_r;
		key_nxt     = key_r;
		in_msg_nxt  = in_msg_r;
		code        = 8'h00;
		sep         = 1'b0;
		estart      = 1'b0;
		endu        = 1'b0;
		if (rx_valid) begin
			in_msg_nxt = !msg_end;
			case (state_r)
			S_UNIT: begin
				if (is_alpha || (c == `CH_COLON) || (c == `CH_STAR)) begin
					state_nxt = S_HDR;
					len_nxt   = is_alpha ? 8'h01 : 8'h00;
					colon_nxt = (c == `CH_COLON);
					qmark_nxt = 1'b0;
					cnt_nxt   = 4'h0;
					key_nxt   = {8'h00, uc};
				end else if (!is_ws && !msg_end && (c != `CH_SEMI))
					code = `E_SYNTAX;
			end
			S_HDR: begin
				if (is_alpha || is_digit || (c == `CH_UNDER)) begin
					if (qmark_r)
						code = `E_HDR_SEP;
					else if (len_r == `MNEM_MAX)
						code = `E_MNEM_LONG;
					else begin
						len_nxt   = len_r + 8'h01;
						colon_nxt = 1'b0;
						key_nxt   = key_step(key_r, c);
					end
				end else if ((c == `CH_COLON) || (c == `CH_QMARK)) begin
					if (colon_r || qmark_r)
						code = `E_HDR;
					else begin
						colon_nxt = (c == `CH_COLON);
						qmark_nxt = (c == `CH_QMARK);
						len_nxt   = 8'h00;
						key_nxt   = key_step(key_r, c);
					end
				end else if (is_ws || (c == `CH_SEMI) || msg_end) begin
					if (colon_r)
						code = `E_HDR;
					else if (!hdr_known)
						code = `E_HDR_UNDEF;
					else if (is_ws)
						state_nxt = S_HWS;
					else
						endu = 1'b1;
				end else if ((c == `CH_DQ) || (c == `CH_SQ) ||
				             (c == `CH_HASH) || (c == `CH_COMMA) ||
				             (c == `CH_LPAR))
					code = `E_HDR_SEP;
				else
					code = `E_INV_CHAR;
			end
			S_HWS: begin
				if ((c == `CH_SEMI) || msg_end)
					endu = 1'b1;
				else if (c == `CH_COMMA)
					code = `E_SYNTAX;
				else if (!is_ws)
					estart = 1'b1;
			end
			S_PSTART: begin
				if ((c == `CH_SEMI) || msg_end || (c == `CH_COMMA))
					code = `E_PAR_MISS;
				else if (!is_ws)
					estart = 1'b1;
			end
			S_NUM: begin
				if (is_digit) begin
					ndig_nxt = 1'b1;
					if (nz_r || (c != `CH_0)) begin
						nz_nxt  = 1'b1;
						dig_nxt = (dig_r == 9'h100) ? dig_r : dig_r + 9'h001;
					end
				end else if (c == `CH_DOT) begin
					if (dot_r)
						code = `E_NUM_CHAR;
					else
						dot_nxt = 1'b1;
				end else if ((uc == `CH_E) && ndig_r) begin
					state_nxt = S_EXP;
					expd_nxt  = 1'b0;
					esgn_nxt  = 1'b0;
				end else if (is_sep) begin
					code = num_err;
					sep  = 1'b1;
				end else if (is_alpha) begin
					code      = num_err;
					state_nxt = S_SFX;
					len_nxt   = 8'h01;
				end else
					code = `E_NUM_CHAR;
			end
			S_EXP: begin
				if (is_digit) begin
					expd_nxt = 1'b1;
					exp_nxt  = (exp_calc[19:16] != 4'h0) ? 16'hFFFF
					                                     : exp_calc[15:0];
				end else if (((c == `CH_PLUS) || (c == `CH_MINUS)) &&
				             !expd_r && !esgn_r)
					esgn_nxt = 1'b1;
				else if (is_sep) begin
					code = num_err;
					sep  = 1'b1;
				end else if (is_alpha) begin
					code      = num_err;
					state_nxt = S_SFX;
					len_nxt   = 8'h01;
				end else
					code = `E_NUM_CHAR;
			end
			S_SFX: begin
				if (is_alpha || is_digit || (c == `CH_SLASH) ||
				    (c == `CH_DOT) || (c == `CH_MINUS)) begin
					if (len_r == `SFX_MAX)
						code = `E_SFX_LONG;
					else
						len_nxt = len_r + 8'h01;
				end else if (is_sep) begin
					if (!sfx_ok)
						code = `E_SFX_NA;
					else
						sep = 1'b1;
				end else
					code = `E_SFX_INV;
			end
			S_NBASE: begin
				if ((uc == `CH_H) || (uc == `CH_Q) || (uc == `CH_B)) begin
					if (!allow_num)
						code = `E_NUM_NA;
					else begin
						state_nxt = S_NDIG;
						ndig_nxt  = 1'b0;
						radix_nxt = (uc == `CH_H) ? 2'h0 :
						            (uc == `CH_Q) ? 2'h1 : 2'h2;
					end
				end else if (is_digit && (c != `CH_0)) begin
					if (!allow_blk)
						code = `E_DTYPE;
					else begin
						state_nxt = S_BLKN;
						bn_nxt    = dv;
						blen_nxt  = 32'h00000000;
					end
				end else
					code = `E_BLK;
			end
			S_NDIG: begin
				if (radix_ok(radix_r, c))
					ndig_nxt = 1'b1;
				else if (is_sep) begin
					code = ndig_r ? 8'h00 : `E_NUM;
					sep  = 1'b1;
				end else
					code = `E_NUM_CHAR;
			end
			S_CHR: begin
				if (is_alpha || is_digit || (c == `CH_UNDER)) begin
					if (len_r == `CHR_MAX)
						code = `E_CHR_LONG;
					else
						len_nxt = len_r + 8'h01;
				end else if (is_sep)
					sep = 1'b1;
				else
					code = `E_CHR_INV;
			end
			S_STR: begin
				if ((c == quote_r) && rx_end)
					endu = 1'b1;
				else if (c == quote_r)
					state_nxt = S_STRQ;
				else if (rx_end)
					code = `E_STR_INV;
			end
			S_STRQ: begin
				if (c == quote_r)
					state_nxt = S_STR;
				else
					sep = 1'b1;
			end
			S_BLKN: begin
				if (msg_end)
					code = `E_BLK_INV;
				else if (is_digit) begin
					blen_nxt = blen_calc[31:0];
					bn_nxt   = bn_r - 4'h1;
					if (bn_r == 4'h1) begin
						lastnum_nxt = 1'b0;
						state_nxt = (blen_calc[31:0] == 32'h0) ? S_AFTER
						                                       : S_BLKD;
					end
				end else
					code = `E_BLK;
			end
			S_BLKD: begin
				blen_nxt = blen_r - 32'h00000001;
				if (blen_r == 32'h00000001) begin
					state_nxt   = S_AFTER;
					lastnum_nxt = 1'b0;
					endu        = rx_end;
				end else if (rx_end)
					code = `E_BLK_INV;
			end
			S_AFTER: begin
				if (is_alpha && lastnum_r) begin
					state_nxt = S_SFX;
					len_nxt   = 8'h01;
				end else if (!is_ws)
					sep = 1'b1;
			end
			S_SKIP: begin
				if (msg_end || (c == `CH_SEMI))
					state_nxt = S_UNIT;
			end
			default: state_nxt = S_UNIT;
			endcase

			if (estart) begin
				dig_nxt  = 9'h000;
				nz_nxt   = is_digit && (c != `CH_0);
				ndig_nxt = is_digit;
				dot_nxt  = (c == `CH_DOT);
				exp_nxt  = 16'h0000;
				expd_nxt = 1'b0;
				if (cnt_r >= param_max)
					code = `E_PAR_EXTRA;
				else begin
					cnt_nxt = cnt_r + 4'h1;
					if (is_digit || (c == `CH_PLUS) ||
					    (c == `CH_MINUS) || (c == `CH_DOT)) begin
						if (!allow_num)
							code = `E_NUM_NA;
						else begin
							state_nxt = S_NUM;
							dig_nxt   = {8'h00, nz_nxt};
						end
					end else if (c == `CH_HASH)
						state_nxt = S_NBASE;
					else if (is_alpha) begin
						if (!allow_chr)
							code = `E_CHR_NA;
						else begin
							state_nxt = S_CHR;
							len_nxt   = 8'h01;
						end
					end else if ((c == `CH_DQ) || (c == `CH_SQ)) begin
						if (!allow_str)
							code = `E_STR_NA;
						else begin
							state_nxt = S_STR;
							quote_nxt = c;
						end
					end else
						code = `E_SYNTAX;
				end
			end

			if (sep && (code == 8'h00)) begin
				if (msg_end || (c == `CH_SEMI))
					endu = 1'b1;
				else if (c == `CH_COMMA)
					state_nxt = S_PSTART;
				else if (is_ws) begin
					state_nxt   = S_AFTER;
					lastnum_nxt = (state_r == S_NUM) || (state_r == S_EXP);
				end else
					code = `E_SEP;
			end

			if (endu && (code == 8'h00)) begin
				if ((state_r != S_UNIT) && (cnt_r < param_min))
					code = `E_PAR_MISS;
				else
					state_nxt = S_UNIT;
			end

			// One entry per unit: the rest of a faulty unit is skipped
			if (code != 8'h00)
				state_nxt = (msg_end || (c == `CH_SEMI)) ? S_UNIT : S_SKIP;
		end
	end

	// Only command-class codes are ever produced here
	assign push      = (code != 8'h00) || get_pend_r;
	assign push_code = (code != 8'h00) ? code : `E_GET;

	always @(posedge clock) begin
		if (reset) begin
			state_r    <= S_UNIT;
			len_r      <= 8'h00;
			dig_r      <= 9'h000;
			nz_r       <= 1'b0;
			ndig_r     <= 1'b0;
			dot_r      <= 1'b0;
			expd_r     <= 1'b0;
			esgn_r     <= 1'b0;
			exp_r      <= 16'h0000;
			cnt_r      <= 4'h0;
			radix_r    <= 2'h0;
			bn_r       <= 4'h0;
			blen_r     <= 32'h00000000;
			quote_r    <= 8'h00;
			colon_r    <= 1'b0;
			qmark_r    <= 1'b0;
			lastnum_r  <= 1'b0;
			key_r      <= 16'h0000;
			in_msg_r   <= 1'b0;
			get_pend_r <= 1'b0;
			cmd_err_r  <= 1'b0;
		end else begin
			state_r    <= state_nxt;
			len_r      <= len_nxt;
			dig_r      <= dig_nxt;
			nz_r       <= nz_nxt;
			ndig_r     <= ndig_nxt;
			dot_r      <= dot_nxt;
			expd_r     <= expd_nxt;
			esgn_r     <= esgn_nxt;
			exp_r      <= exp_nxt;
			cnt_r      <= cnt_nxt;
			radix_r    <= radix_nxt;
			bn_r       <= bn_nxt;
			blen_r     <= blen_nxt;
			quote_r    <= quote_nxt;
			colon_r    <= colon_nxt;
			qmark_r    <= qmark_nxt;
			lastnum_r  <= lastnum_nxt;
			key_r      <= key_nxt;
			in_msg_r   <= in_msg_nxt;
			// A trigger that collides with a parse fault waits for the next cycle with no fault
			get_pend_r <= (get_trig && in_msg_r) ||
			              (get_pend_r && (code != 8'h00));
			// Set wins over a clear in the same cycle
			cmd_err_r  <= push ? 1'b1 :
			              clear_status ? 1'b0 : cmd_err_r;
		end
	end

	error_queue u_queue (
		.clock      (clock),
		.reset      (reset),
		.clear      (clear_status),
		.push       (push),
		.push_code  (push_code),
		.read       (err_read),
		.err_code_r (err_code),
		.err_ack_r  (err_ack)
	);

	assign esr_cmd_err = cmd_err_r;
	assign hdr_key     = key_r;

endmodule

// *** verif/hdr_table_model.sv ***
// Header table model: answers the parser's key lookup.
// Assumes upper-case headers; knows VOLT, LBL and CNT only.
`timescale 1ns/1ps
module hdr_table_model (
	input  wire [15:0] hdr_key,
	output wire        hdr_known,
	output wire [3:0]  param_min,
	output wire [3:0]  param_max,
	output wire        allow_num,
	output wire        allow_chr,
	output wire        allow_str,
	output wire        allow_blk,
	output wire        sfx_ok
);
	reg [13:0] ans;
	function [15:0] key_of(input string s);
		key_of = {8'h00, s[0]};
		for (int i = 1; i < s.len(); i++)
			key_of = {key_of[14:0], 1'b0} ^ {8'h00, s[i]};
	endfunction
	// Answer is combinational, as the parser samples it with no latency
	always @* begin
		ans = 14'h0000;
		if (hdr_key === key_of("VOLT"))
			ans = {1'b1, 4'h1, 4'h2, 5'b10001};
		if (hdr_key === key_of("LBL"))
			ans = {1'b1, 4'h1, 4'h1, 5'b01110};
		if (hdr_key === key_of("CNT"))
			ans = {1'b1, 4'h0, 4'h1, 5'b10000};
	end
	assign {hdr_known, param_min, param_max, allow_num, allow_chr,
		allow_str, allow_blk, sfx_ok} = ans;
endmodule

// *** verif/scpi_checker_sva.sv ***
// Checker for the error queue read port and the command-error flag.
// Sees only top-level ports; attached by bind.
`timescale 1ns/1ps
module scpi_checker (
	input wire        clock,
	input wire        reset,
	input wire        rx_valid,
	input wire        get_trig,
	input wire        clear_status,
	input wire        err_read,
	input wire [15:0] err_code,
	input wire        err_ack,
	input wire        esr_cmd_err
);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	AST_ACK_AFTER_READ: assert property (err_read |=> err_ack)
		else $error("read not acknowledged");
	AST_ACK_ONLY_READ: assert property (!err_read |=> !err_ack)
		else $error("ack without read");
	AST_CODE_HOLD: assert property (!err_read |=> $stable(err_code))
		else $error("code changed without read");
	AST_CODE_RANGE: assert property (err_ack |->
		err_code == 16'h0000 || (err_code >= 16'hFF39 && err_code <= 16'hFF9C))
		else $error("code outside command class");
	AST_ESR_STICKY: assert property (esr_cmd_err && !clear_status |=>
		esr_cmd_err)
		else $error("error flag dropped");
	// GET entries land one or two edges late, so they may still set the flag
	AST_ESR_CLEAR: assert property (clear_status && !rx_valid &&
		!$past(get_trig) && !$past(get_trig, 2) |=> !esr_cmd_err)
		else $error("flag survived clear");
	AST_CLR_READ_ZERO: assert property (clear_status && err_read |=>
		err_code == 16'h0000)
		else $error("read during clear not empty");
	AST_ACK_ERR_ESR: assert property (err_ack && err_code != 16'h0000 |->
		esr_cmd_err)
		else $error("entry read without flag");
	cover property (err_ack && err_code != 16'h0000);
	cover property (clear_status && err_read);
	cover property ($rose(esr_cmd_err));
endmodule
bind scpi_parser_error_classifier scpi_checker chk (.clock(clock),
	.reset(reset), .rx_valid(rx_valid), .get_trig(get_trig),
	.clear_status(clear_status), .err_read(err_read),
	.err_code(err_code), .err_ack(err_ack), .esr_cmd_err(esr_cmd_err));

// *** verif/scpi_parser_error_classifier_bench.sv ***
// Self-checking bench: sends program messages, reads the error queue.
// Assumes the header table model beside the parser.
`timescale 1ns/1ps
module scpi_parser_error_classifier_bench;
	reg clock = 0, reset = 1, rx_valid = 0, rx_end = 0, get_trig = 0;
	reg clear_status = 0, err_read = 0;
	reg [7:0] rx_byte = 8'h00;
	wire [15:0] err_code, hdr_key;
	wire [3:0] param_min, param_max;
	wire err_ack, esr_cmd_err, hdr_known, allow_num, allow_chr;
	wire allow_str, allow_blk, sfx_ok;
	integer seed, n_errors = 0, checks = 0, cyc = 0, k;
	string ms[$], d, z;
	int mg[$];
	bit gs[$];
	always #2.5 clock = ~clock;
	scpi_parser_error_classifier DUT (.clock(clock), .reset(reset),
		.rx_valid(rx_valid), .rx_byte(rx_byte), .rx_end(rx_end),
		.get_trig(get_trig), .clear_status(clear_status),
		.err_read(err_read), .hdr_known(hdr_known), .param_min(param_min),
		.param_max(param_max), .allow_num(allow_num), .allow_chr(allow_chr),
		.allow_str(allow_str), .allow_blk(allow_blk), .sfx_ok(sfx_ok),
		.err_code(err_code), .err_ack(err_ack), .esr_cmd_err(esr_cmd_err),
		.hdr_key(hdr_key));
	hdr_table_model tbl (.hdr_key(hdr_key), .hdr_known(hdr_known),
		.param_min(param_min), .param_max(param_max),
		.allow_num(allow_num), .allow_chr(allow_chr),
		.allow_str(allow_str), .allow_blk(allow_blk), .sfx_ok(sfx_ok));
	function [15:0] code_of(input int m);
		code_of = 16'h0000 - m[15:0];
	endfunction
	task wrap_up;
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk16(input [15:0] got, input [15:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task chk1(input got, input exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Random idle gaps: the parser must not depend on back-to-back bytes
	task send(input string s, input bit g);
		for (int i = 0; i < s.len(); i++) begin
			@(posedge clock);
			rx_valid <= 1;
			rx_byte <= s[i];
			rx_end <= (i == s.len() - 1) && (s[i] != 8'h0A);
			get_trig <= g && i == 3;
			if (($random(seed) & 3) == 0) begin
				@(posedge clock);
				rx_valid <= 0;
				get_trig <= 0;
			end
		end
		@(posedge clock);
		rx_valid <= 0;
		rx_end <= 0;
		get_trig <= 0;
	endtask
	task pop(input int m, input bit clr);
		@(posedge clock);
		err_read <= 1;
		clear_status <= clr;
		@(posedge clock);
		err_read <= 0;
		clear_status <= 0;
		#1;
		chk1(err_ack, 1'b1);
		chk16(err_code, code_of(m));
	endtask
	task add(input string s, input int m, input bit g = 0);
		ms.push_back(s);
		mg.push_back(m);
		gs.push_back(g);
	endtask
	// A GET between messages goes first: it must leave no entry
	task run(input string s, input int m, input bit g);
		@(posedge clock);
		get_trig <= 1;
		send(s, g);
		repeat (2) @(posedge clock);
		#1;
		chk1(esr_cmd_err, m != 0);
		pop(m, 0);
		pop(0, 0);
		pop(0, 1);
		$display("test done, code %0d", -m);
	endtask
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_errors++;
			wrap_up;
		end
	end
	initial begin
		seed = 32'hC696D16A;
		repeat (2) @(posedge clock);
		reset <= 0;
		add("VOLT 1\n", 0);
		add("CNT\n", 0);
		add("*XYZ\n", 113);
		add("ABCDEFGHIJKLM\n", 112);
		add("VOLT 1E32001\n", 123);
		add("VOLT 1E32000\n", 0);
		add("VOLT 5ABCDEFGHIJKLM\n", 134);
		add("LBL ABCDEFGHIJKLM\n", 144);
		add("VOLT 1,2,3\n", 108);
		add("VOLT\n", 109);
		add("VOLT::A\n", 110);
		add("VO&LT\n", 101);
		add("1VOLT\n", 102);
		add("VOLT 1 2\n", 103);
		add("VOLT #15ABCDE\n", 104);
		add("VOLT\"5\"\n", 111);
		add("VOLT 1.2.3\n", 121);
		add("LBL 5\n", 128);
		add("CNT 5V\n", 138);
		add("VOLT 5V&\n", 131);
		add("VOLT ABC\n", 148);
		add("LBL \"AB", 151);
		add("VOLT \"A\"\n", 158);
		add("LBL #15AB", 161);
		add("LBL #1X\n", 160);
		add("VOLT 1\n", 105, 1);
		d = "VOLT ";
		z = "VOLT 00";
		repeat (255) begin
			d = {d, "1"};
			z = {z, "1"};
		end
		add({d, "1\n"}, 124);
		add({z, "\n"}, 0);
		foreach (ms[i]) run(ms[i], mg[i], gs[i]);
		// Nine faulty units: the ninth is dropped, order is kept
		send("*XY;ABCDEFGHIJKLM;VOLT;*XY;*XY;*XY;*XY;*XY;*XY\n", 0);
		chk16(hdr_key, tbl.key_of("*XY"));
		pop(113, 0);
		pop(112, 0);
		pop(109, 0);
		repeat (5) pop(113, 0);
		pop(0, 0);
		// A read in the clear cycle sees an empty queue, then it stays empty
		send("*XY;*XY\n", 0);
		pop(0, 1);
		pop(0, 0);
		$display("test done, queue overflow and clear");
		repeat (30) begin
			k = {$random(seed)} % ms.size();
			run(ms[k], mg[k], gs[k]);
		end
		wrap_up;
	end
endmodule
